// ### sim/stc_pad_model.sv
// Behavioural sensor pads feeding readings to the standby sampling control
`timescale 1ns/1ps
module stc_pad_model
   import stc_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Sampling request from the block
   input wire logic sense_en_q,
   input wire logic [1:0] sense_chan_q,
   // Touch offset above the untouched level, per pad
   input wire logic [2:0][15:0] touch_amt,
   // Reading back to the block
   output logic [15:0] sense_count
);
   logic [15:0] last_q;
   // Outside a sample the reading flips every cycle, so a stray capture never looks valid
   always_ff @(posedge sys_clk) begin
      last_q <= sense_count;
   end
   // Untouched pads read the reset baseline, so recalibration leaves it in place
   always_comb begin
      sense_count = sense_en_q ? (16'h00c8 + touch_amt[sense_chan_q]) : ~last_q;
   end
endmodule : stc_pad_model

// ### sim/tb_top.sv
// Self-checking bench for the standby touch sampling control
`timescale 1ns/1ps
module tb_top;
   import stc_pkg::*;
   localparam int SB = 4;
   localparam int CB = 40;
   // ==========================================================
   // Signals
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic [1:0] last_ch = 2'd0;
   logic standby_active = 1'b0;
   logic [3:0] base_shift = 4'h0;
   stc_reg_req_t reg_req = '0;
   logic [7:0] reg_rdata_q;
   logic [15:0] sense_count;
   logic sense_en_q, low_power_q, meas_done_q;
   logic [1:0] sense_chan_q;
   logic [2:0] touch_q;
   logic [2:0][15:0] amt = '0;
   int n_fail = 0, check_count = 0, cyc = 0, seed = 78, run = 0, run_c = 0;
   always #10 sys_clk = ~sys_clk;
   // ==========================================================
   // Design and pads
   stc_standby_ctrl #(.SAMP_BASE(SB), .CYC_BASE(CB)) u_stc_standby_ctrl (
      .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .reg_req(reg_req),
      .reg_rdata_q(reg_rdata_q), .standby_active(standby_active), .base_shift(base_shift),
      .sense_count(sense_count), .sense_en_q(sense_en_q), .sense_chan_q(sense_chan_q),
      .low_power_q(low_power_q), .touch_q(touch_q), .meas_done_q(meas_done_q));
   stc_pad_model u_stc_pad_model (.sys_clk(sys_clk), .sense_en_q(sense_en_q),
      .sense_chan_q(sense_chan_q), .touch_amt(amt), .sense_count(sense_count));
   // Burst length of the last channel, and the hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      // The channel index moves on at the done pulse, so keep the one just sampled
      if (sense_en_q) begin
         last_ch <= sense_chan_q;
         run_c <= run_c + 1;
      end else if (run_c != 0) begin
         run <= run_c;
         run_c <= 0;
      end
      if (cyc == 100000) begin
         n_fail++;
         results();
      end
   end
   // ==========================================================
   // Helpers
   task automatic results();
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk) reg_req <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk) reg_req <= '0;
      #1 chk(16'(reg_rdata_q), 16'(e));
   endtask : rd
   // Waits until a done pulse is seen, one edge on at least so a pulse is not counted twice
   task automatic wait_done();
      int i;
      @(posedge sys_clk);
      #1;
      for (i = 0; i < 20000 && meas_done_q !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(16'(meas_done_q), 16'h0001);
   endtask : wait_done
   // Touch expected from offset d, mode, count, gain and threshold
   function automatic logic exp_touch(logic [7:0] cfg, logic [2:0] g, logic [6:0] thr,
                                      logic [15:0] d);
      logic [31:0] v;
      v = cfg[7] ? (32'(d) << cfg[6:4]) : 32'(d);
      v = v << (3'd7 - g);
      if (v > 32'd255) v = 32'd255;
      return v > 32'(thr);
   endfunction : exp_touch
   // One programmed setting, two full standby cycles
   task automatic meas(input logic [7:0] cfg, input logic [2:0] g, input logic [6:0] thr,
                       input logic [2:0] en);
      int ch, p, len, tot;
      int tch[3];
      logic ovr;
      @(posedge sys_clk) standby_active <= 1'b0;
      // A lone calc cycle is also quiet, so the quiet test is made twice
      for (p = 0; p < 2; p++) begin
         repeat (3) @(posedge sys_clk);
         #1;
         for (ch = 0; ch < 20000 && (sense_en_q !== 1'b0 || low_power_q !== 1'b0); ch++) begin
            @(posedge sys_clk);
            #1;
         end
      end
      wr(OFS_CFG, cfg);
      wr(OFS_GAIN, {5'h00, g});
      wr(OFS_THR, {1'b0, thr});
      wr(OFS_CHAN_EN, {5'h00, en});
      // small offsets keep sum mode in the proximity range
      for (ch = 0; ch < 3; ch++) amt[ch] <= 16'($random(seed) & 31);
      len = (SB << cfg[3:2]) << cfg[6:4];
      // Each channel also spends one combine cycle inside the cycle
      tot = (en[0] + en[1] + en[2]) * (len + 1);
      ovr = tot >= CB * (cfg[1:0] + 1);
      @(posedge sys_clk) standby_active <= 1'b1;
      for (p = 0; p < 2; p++) begin
         for (ch = 0; ch < 3; ch++) begin
            if (en[ch]) begin
               wait_done();
               chk(16'(last_ch), 16'(ch));
               chk(16'(touch_q[ch]), 16'(exp_touch(cfg, g, thr, amt[ch])));
               chk(16'(run), 16'(len));
               if (p == 0) tch[ch] = cyc;
               if (p == 1 && !ovr) chk(16'(cyc - tch[ch]), 16'(CB * (cfg[1:0] + 1)));
               if (p == 1 && ovr) chk(16'(cyc - tch[ch]), 16'(tot));
               if (!ovr && ((en >> (ch + 1)) == 3'd0)) chk(16'(low_power_q), 16'h0001);
            end
         end
      end
   endtask : meas
   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] v;
      int k;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(OFS_CHAN_EN, 8'h00);
      rd(OFS_CFG, 8'h39);
      rd(OFS_GAIN, 8'h02);
      rd(OFS_THR, 8'h40);
      // Clock enable low: the write must not land
      @(posedge sys_clk) ce <= 1'b0;
      wr(OFS_THR, 8'h11);
      ce <= 1'b1;
      rd(OFS_THR, 8'h40);
      for (k = 0; k < 3; k++) rd(OFS_BASE1 + 8'(k), 8'hc8);
      wr(OFS_BASE2, 8'hff);
      rd(OFS_BASE2, 8'hc8);
      rd(8'h44, 8'h00);
      for (k = 0; k < 6; k++) begin
         v = 8'($random(seed));
         wr(OFS_CFG, v);
         rd(OFS_CFG, v);
         wr(OFS_GAIN, v);
         rd(OFS_GAIN, {5'h00, v[2:0]});
         wr(OFS_THR, v);
         rd(OFS_THR, {1'b0, v[6:0]});
      end
      for (k = 0; k < 16; k++) begin
         @(posedge sys_clk) base_shift <= 4'(k);
         rd(OFS_BASE3, 8'(16'h00c8 >> k));
      end
      meas(8'h00, 3'd0, 7'd40, 3'b001);
      meas(8'h01, 3'd7, 7'h00, 3'b111);
      meas(8'hb2, 3'd3, 7'h7f, 3'b111);
      meas(8'h39, 3'd2, 7'h40, 3'b101);
      meas(8'h7c, 3'd5, 7'h10, 3'b010);
      for (k = 0; k < 4; k++) begin
         v = 8'($random(seed));
         meas({v[7], 1'b0, v[5:4], 2'b00, v[1:0]}, 3'($random(seed)), 7'($random(seed)),
              3'($random(seed)) | 3'b001);
      end
      // Mid-run reset, then 256 untouched readings pull baseline 1 to the pad level
      @(posedge sys_clk) rst_b <= 1'b0;
      standby_active <= 1'b0;
      base_shift <= 4'h0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(OFS_BASE1, 8'hc8);
      wr(OFS_GAIN, 8'h07);
      wr(OFS_THR, 8'h7f);
      wr(OFS_CFG, 8'h00);
      wr(OFS_CHAN_EN, 8'h01);
      amt <= {16'd0, 16'd0, 16'd5};
      @(posedge sys_clk) standby_active <= 1'b1;
      for (k = 0; k < 256; k++) wait_done();
      rd(OFS_BASE1, 8'hcd);
      rd(OFS_BASE2, 8'hc8);
      results();
   end
endmodule : tb_top

// ### src/stc_pkg.sv
// Constants, register map and carrier types for the standby touch sampling control
package stc_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_CHAN_EN = 8'h40;
   localparam logic [7:0] OFS_CFG = 8'h41;
   localparam logic [7:0] OFS_GAIN = 8'h42;
   localparam logic [7:0] OFS_THR = 8'h43;
   localparam logic [7:0] OFS_BASE1 = 8'h50;
   localparam logic [7:0] OFS_BASE2 = 8'h51;
   localparam logic [7:0] OFS_BASE3 = 8'h52;
   // ==========================================================
   // Reset values
   localparam logic [2:0] RST_CHAN_EN = 3'h0;
   localparam logic [7:0] RST_CFG = 8'h39;
   localparam logic [2:0] RST_GAIN = 3'h2;
   localparam logic [6:0] RST_THR = 7'h40;
   localparam logic [15:0] RST_BASE = 16'h00C8;
   // ==========================================================
   // Timing: times in their own unit, counts derived from the clock rate
   localparam int CLK_MHZ = 50;
   localparam int SAMP_TIME_BASE_US = 320;
   localparam int CYC_TIME_BASE_MS = 35;
   localparam int SAMP_BASE_CYC = SAMP_TIME_BASE_US * CLK_MHZ;
   localparam int CYC_BASE_CYC = CYC_TIME_BASE_MS * 1000 * CLK_MHZ;
   // ==========================================================
   // Sizes
   localparam int NUM_CH = 3;
   localparam logic [7:0] RECAL_LAST = 8'hFF;   // 256 readings per base update
   // ==========================================================
   // Types
   typedef struct packed {
      logic accumulate_not_mean;
      logic [2:0] standby_sample_count_sel;
      logic [1:0] standby_sample_period_sel;
      logic [1:0] standby_cycle_period_sel;
   } stc_cfg_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } stc_reg_req_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SAMP = 4'b0010,
      ST_CALC = 4'b0100,
      ST_SLEEP = 4'b1000
   } stc_state_t;
endpackage : stc_pkg

// ### src/stc_standby_ctrl.sv
// Standby sampling sequencer, delta/touch evaluation and baseline recalibration
`timescale 1ns/1ps
// How it works
// - Mode bit chooses mean or sum of samples for the delta count.
// - Sample-count code 0..7 selects 1..128 samples; reset selects 8.
// - All samples of one channel back to back, combine, then next channel.
// - Sample-period code selects 320us, 640us, 1.28ms, 2.56ms; reset 1.28ms.
// - Cycle-period code selects 35, 70, 105, 140 ms; reset 70ms.
// - Sample all enabled channels at cycle start, then low power for the rest.
// - If sampling outlasts the cycle, the cycle is lengthened.
// - Gain code 0..7 scales delta 128x down to 1x; reset 32x.
// - Gain multiplies the relative delta count.
// - Touch when delta exceeds seven-bit threshold; reset 40h.
// - Read-only baselines hold untouched value, refreshed, reset C8h.
// - Recal adds readings until sample size, upper 16 bits become baseline.
// - Shown baseline is scaled by the four-bit shift field.
// - Standby channels use standby threshold, averaging and gain.
// - Per-channel standby enables select sampled channels; all off after reset.
module stc_standby_ctrl
   import stc_pkg::*;
#(
   parameter int SAMP_BASE = SAMP_BASE_CYC,
   parameter int CYC_BASE = CYC_BASE_CYC
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Register port
   input wire stc_reg_req_t reg_req,
   output logic [7:0] reg_rdata_q,
   // Device context
   input wire logic standby_active,
   input wire logic [3:0] base_shift,
   // Sensor front end
   input wire logic [15:0] sense_count,
   output logic sense_en_q,
   output logic [1:0] sense_chan_q,
   output logic low_power_q,
   // Results
   output logic [2:0] touch_q,
   output logic meas_done_q
);
   // ==========================================================
   // Helpers
   // Lowest enabled channel with index at or above lo; 3 means none
   function automatic logic [1:0] pick_chan(input logic [2:0] en, input logic [1:0] lo);
      logic [1:0] r;
      r = 2'd3;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (en[i] && (2'(i) >= lo)) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction : pick_chan

   // Baseline as presented after the shift
   function automatic logic [7:0] shown_base(input logic [15:0] b, input logic [3:0] s);
      return 8'(b >> s);
   endfunction : shown_base

   // ==========================================================
   // Registers
   logic [2:0] chan_en_q;
   stc_cfg_t cfg_q;
   logic [2:0] gain_q;
   logic [6:0] thr_q;
   logic [15:0] base_q [NUM_CH];
   logic [23:0] rc_acc_q [NUM_CH];
   logic [7:0] rc_cnt_q [NUM_CH];

   // Software writes; baselines are not writable
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_en_q <= RST_CHAN_EN;
         cfg_q <= RST_CFG;
         gain_q <= RST_GAIN;
         thr_q <= RST_THR;
      end else if (ce && reg_req.wr) begin
         if (reg_req.addr == OFS_CHAN_EN) chan_en_q <= reg_req.wdata[2:0];
         if (reg_req.addr == OFS_CFG) cfg_q <= reg_req.wdata;
         if (reg_req.addr == OFS_GAIN) gain_q <= reg_req.wdata[2:0];
         if (reg_req.addr == OFS_THR) thr_q <= reg_req.wdata[6:0];
      end
   end

   // Read data, one cycle after the request; unmapped reads zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= 8'h00;
      end else if (ce && reg_req.rd) begin
         unique case (reg_req.addr)
            OFS_CHAN_EN: reg_rdata_q <= {5'h00, chan_en_q};
            OFS_CFG: reg_rdata_q <= cfg_q;
            OFS_GAIN: reg_rdata_q <= {5'h00, gain_q};
            OFS_THR: reg_rdata_q <= {1'b0, thr_q};
            OFS_BASE1: reg_rdata_q <= shown_base(base_q[0], base_shift);
            OFS_BASE2: reg_rdata_q <= shown_base(base_q[1], base_shift);
            OFS_BASE3: reg_rdata_q <= shown_base(base_q[2], base_shift);
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Timing decode
   logic [31:0] samp_len;
   logic [31:0] cyc_len;
   logic [7:0] samp_last;
   assign samp_len = 32'(SAMP_BASE) << cfg_q.standby_sample_period_sel;
   // cycle period in 35 ms steps
   assign cyc_len = 32'(CYC_BASE) * (32'(cfg_q.standby_cycle_period_sel) + 32'd1);
   // samples per measurement is a power of two
   assign samp_last = 8'((9'd1 << cfg_q.standby_sample_count_sel) - 9'd1);

   // ==========================================================
   // Sequencer
   stc_state_t state_q;
   logic [31:0] tick_q;
   logic [31:0] cyc_cnt_q;
   logic [7:0] samp_idx_q;
   logic [22:0] acc_q;
   logic [1:0] first_ch;
   logic [1:0] next_ch;
   logic can_run;
   logic cyc_over;

   assign first_ch = pick_chan(chan_en_q, 2'd0);
   assign next_ch = (sense_chan_q == 2'd2) ? 2'd3 : pick_chan(chan_en_q, sense_chan_q + 2'd1);
   assign can_run = standby_active && (first_ch != 2'd3);
   assign cyc_over = cyc_cnt_q >= cyc_len - 32'd1;

   // State and sensor drive; the cycle counter runs on through sampling so
   // an overlong sampling pass simply pushes the next start out
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         tick_q <= 32'd0;
         cyc_cnt_q <= 32'd0;
         samp_idx_q <= 8'd0;
         acc_q <= 23'd0;
         sense_en_q <= 1'b0;
         sense_chan_q <= 2'd0;
         low_power_q <= 1'b0;
      end else if (ce) begin
         cyc_cnt_q <= cyc_cnt_q + 32'd1;
         unique case (state_q)
            ST_IDLE: begin
               if (can_run) begin
                  state_q <= ST_SAMP;
                  cyc_cnt_q <= 32'd0;
                  sense_chan_q <= first_ch;
                  sense_en_q <= 1'b1;
               end
            end
            ST_SAMP: begin
               tick_q <= tick_q + 32'd1;
               if (tick_q == samp_len - 32'd1) begin
                  tick_q <= 32'd0;
                  acc_q <= acc_q + {7'h00, sense_count};
                  samp_idx_q <= samp_idx_q + 8'd1;
                  if (samp_idx_q == samp_last) begin
                     samp_idx_q <= 8'd0;
                     sense_en_q <= 1'b0;
                     state_q <= ST_CALC;
                  end
               end
            end
            ST_CALC: begin
               acc_q <= 23'd0;
               if (next_ch != 2'd3) begin
                  state_q <= ST_SAMP;
                  sense_chan_q <= next_ch;
                  sense_en_q <= 1'b1;
               // cycle already used up: start again at once
               end else if (cyc_over && can_run) begin
                  state_q <= ST_SAMP;
                  cyc_cnt_q <= 32'd0;
                  sense_chan_q <= first_ch;
                  sense_en_q <= 1'b1;
               end else begin
                  // rest of the cycle in low power
                  state_q <= ST_SLEEP;
                  low_power_q <= 1'b1;
               end
            end
            ST_SLEEP: begin
               if (!standby_active) begin
                  state_q <= ST_IDLE;
                  low_power_q <= 1'b0;
               end else if (cyc_over && can_run) begin
                  state_q <= ST_SAMP;
                  low_power_q <= 1'b0;
                  cyc_cnt_q <= 32'd0;
                  sense_chan_q <= first_ch;
                  sense_en_q <= 1'b1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Delta evaluation
   logic [15:0] mean16;
   logic [15:0] base_cur;
   logic [22:0] val;
   logic [22:0] ref_v;
   logic [22:0] raw;
   logic [29:0] scaled;
   logic [7:0] delta8;
   logic hit;

   always_comb begin
      base_cur = base_q[sense_chan_q];
      mean16 = 16'(acc_q >> cfg_q.standby_sample_count_sel);
      // mean or sum, against a baseline scaled to match
      if (cfg_q.accumulate_not_mean) begin
         val = acc_q;
         ref_v = 23'({7'h00, base_cur} << cfg_q.standby_sample_count_sel);
      end else begin
         val = {7'h00, mean16};
         ref_v = {7'h00, base_cur};
      end
      raw = (val > ref_v) ? val - ref_v : 23'd0;
      // gain multiplies the relative delta; 128x at code 0
      scaled = 30'({7'h00, raw} << (3'd7 - gain_q));
      delta8 = (|scaled[29:8]) ? 8'hFF : scaled[7:0];
      // strictly above threshold; standby settings only
      hit = delta8 > {1'b0, thr_q};
   end

   // Touch flags and completion pulse
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         touch_q <= 3'b000;
         meas_done_q <= 1'b0;
      end else if (ce) begin
         meas_done_q <= (state_q == ST_CALC);
         if (state_q == ST_CALC) touch_q[sense_chan_q] <= hit;
      end
   end

   // ==========================================================
   // Recalibration; touched readings are left out so a held finger
   // cannot drag the baseline toward itself
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_CH; i++) begin
            base_q[i] <= RST_BASE;
            rc_acc_q[i] <= 24'd0;
            rc_cnt_q[i] <= 8'd0;
         end
      end else if (ce && state_q == ST_CALC && !hit) begin
         // accumulate, take upper 16 bits, clear
         rc_acc_q[sense_chan_q] <= rc_acc_q[sense_chan_q] + {8'h00, mean16};
         rc_cnt_q[sense_chan_q] <= rc_cnt_q[sense_chan_q] + 8'd1;
         if (rc_cnt_q[sense_chan_q] == RECAL_LAST) begin
            base_q[sense_chan_q] <= 16'((rc_acc_q[sense_chan_q] + {8'h00, mean16}) >> 8);
            rc_acc_q[sense_chan_q] <= 24'd0;
         end
      end
   end

   // ==========================================================
   // Assertions
   sequence s_read_cfg;
      ce && reg_req.rd && reg_req.addr == OFS_CFG;
   endsequence
   sequence s_chan_end;
      ce && state_q == ST_SAMP && tick_q == samp_len - 32'd1 && samp_idx_q == samp_last;
   endsequence

   a_cfg_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_read_cfg |=> reg_rdata_q == $past(cfg_q))
      else $error("config readback wrong");
   a_chan_combine: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_chan_end |=> state_q == ST_CALC && !sense_en_q)
      else $error("channel not combined after last sample");
   a_touch_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (meas_done_q && $past(ce)) |-> touch_q[$past(sense_chan_q)] == $past(hit))
      else $error("touch flag mismatch");
   a_enabled_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(sense_en_q) |-> ($past(chan_en_q) & (3'b001 << sense_chan_q)) != 3'b000)
      else $error("disabled channel sampled");
   a_sleep_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
      low_power_q |-> !sense_en_q && state_q == ST_SLEEP)
      else $error("sampling during low power");
   a_cycle_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ce && state_q == ST_SLEEP && standby_active && can_run && cyc_over)
      |=> cyc_cnt_q == 32'd0 && sense_en_q)
      else $error("cycle restart wrong");
   a_sample_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (sense_en_q && $past(sense_en_q)) |-> $stable(sense_chan_q))
      else $error("channel changed mid sampling");
   a_delta_clip: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_q == ST_CALC && raw >= 23'd256) |-> delta8 == 8'hFF)
      else $error("delta wrapped");
   a_base_update: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ce && state_q == ST_CALC && !hit && rc_cnt_q[sense_chan_q] == RECAL_LAST)
      |=> rc_acc_q[$past(sense_chan_q)] == 24'd0)
      else $error("recal adder not cleared");
endmodule : stc_standby_ctrl
